/* design/prc_regs.svh */
// Register offsets, field positions and reset values for the checker
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
// Register byte offsets
`define PRC_OFS_CTRL     8'h00
`define PRC_OFS_STAT     8'h04
`define PRC_OFS_CLR      8'h08
`define PRC_OFS_EN       8'h0c
// Control register fields
`define PRC_C_SYSTEM_ERR_ENABLE    0
`define PRC_C_PARITY_RESPONSE_ENABLE     1
`define PRC_C_SPERESP    2
`define PRC_C_FATAL_EN   3
`define PRC_C_NFATAL_EN  4
`define PRC_C_COR_EN     5
`define PRC_C_ECRC_SEV   6
`define PRC_C_MAL_SEV    7
`define PRC_C_POIS_SEV   8
`define PRC_C_RCB128     9
`define PRC_C_MPS_LO     10
`define PRC_C_MPS_HI     12
`define PRC_CTRL_W       13
`define PRC_CTRL_RST     13'h0080
// Status, clear and enable fields
`define PRC_S_ECRC       0
`define PRC_S_POISON     1
`define PRC_S_MAL        2
`define PRC_S_ADVISORY_NONFATAL_FLAG       3
`define PRC_S_DPE        4
`define PRC_S_SSERR      5
`define PRC_S_FATAL      6
`define PRC_S_NFATAL     7
`define PRC_S_COR        8
`define PRC_S_MDP_PRI    9
`define PRC_S_SEC_PERR   10
`define PRC_S_MDP_SEC    11
`define PRC_STAT_W       12
`define PRC_STAT_RST     12'h000
`endif

/* design/prc_pkg.sv */
// Types shared by the receive packet error checker
package prc_pkg;
    `include "prc_regs.svh"

    // Decoded header of one received packet, valid for one cycle
    typedef struct packed {
        logic        valid;          // Packet present this cycle
        logic [1:0]  fmt;            // Format field
        logic [4:0]  typ;            // Type field
        logic [2:0]  tc;             // Traffic class
        logic [1:0]  attr;           // Attributes
        logic        td;             // Digest-present header bit
        logic        ep;             // Poisoned bit
        logic [9:0]  len;            // Length field, 0 means 1024 DW
        logic [9:0]  addr_dw;        // Address bits 11:2
        logic [3:0]  first_byte_enables;
        logic [3:0]  last_byte_enables;
        logic [7:0]  msg_code;       // Message code
        logic [10:0] payload_dw;     // Payload words actually received
        logic        ecrc_present;   // CRC word appended
        logic        ecrc_bad;       // Appended CRC word did not match
        logic [2:0]  cpl_status;     // Completion status
        logic [11:0] byte_count;     // Completion byte count, 0 means 4096
        logic [6:0]  lower_addr;     // Completion lower address
        logic        req_was_cfg;    // Matching request was a configuration request
    } prc_pkt_s;

    // Secondary forward tracking
    typedef enum logic [1:0] {
        FWD_IDLE = 2'b01,
        FWD_WAIT = 2'b10
    } prc_fwd_e;

    // Whole state of the checker
    typedef struct packed {
        logic [`PRC_CTRL_W-1:0] ctrl;
        logic [`PRC_STAT_W-1:0] stat;
        logic [`PRC_STAT_W-1:0] en;
        logic [31:0]            rdata;
        logic                   perr_s1;
        logic                   perr_s2;
        prc_fwd_e               fwd;
        logic                   pass;
        logic                   drop;
        logic                   msg_fatal;
        logic                   msg_nonfatal;
        logic                   msg_cor;
        logic                   irq;
    } prc_state_s;
endpackage : prc_pkg

/* design/prc_rx_checker.sv */
// Receive-side packet error checker with status, message and drop decisions
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module prc_rx_checker
    import prc_pkg::*;
(
    input  wire logic        clk,                 // Core clock, 200 MHz
    input  wire logic        rst_n,               // Asynchronous reset, active low
    input  prc_pkt_s         in_pkt,              // Decoded received packet
    input  wire logic        sec_fwd_done,        // Poisoned write reached the parallel bus
    input  wire logic        parity_error_pin_n,  // Parity error pin, active low, async
    input  wire logic [7:0]  reg_addr,            // Register byte address
    input  wire logic [31:0] reg_wdata,           // Register write data
    input  wire logic        reg_wr,              // Write strobe
    input  wire logic        reg_rd,              // Read strobe
    output logic      [31:0] reg_rdata,           // Read data, cycle after strobe
    output logic             pkt_pass,            // Packet may be forwarded or used
    output logic             pkt_drop,            // Packet dropped or discarded
    output logic             msg_fatal,           // Send fatal error message
    output logic             msg_nonfatal,        // Send non-fatal error message
    output logic             msg_cor,             // Send correctable error message
    output logic             irq                  // Level interrupt
);

    prc_state_s st_ff;   // Registered state
    prc_state_s nxt_st;  // Next state

    // Control field views
    logic        system_err_enable;
    logic        perresp;
    logic        speresp;
    logic        fatal_en;
    logic        nfatal_en;
    logic        cor_en;
    logic [2:0]  mps;
    assign system_err_enable   = st_ff.ctrl[`PRC_C_SYSTEM_ERR_ENABLE];
    assign perresp   = st_ff.ctrl[`PRC_C_PARITY_RESPONSE_ENABLE];
    assign speresp   = st_ff.ctrl[`PRC_C_SPERESP];
    assign fatal_en  = st_ff.ctrl[`PRC_C_FATAL_EN];
    assign nfatal_en = st_ff.ctrl[`PRC_C_NFATAL_EN];
    assign cor_en    = st_ff.ctrl[`PRC_C_COR_EN];
    assign mps       = st_ff.ctrl[`PRC_C_MPS_HI:`PRC_C_MPS_LO];

    // Type decode
    logic mem_req;
    logic is_io;
    logic is_cfg;
    logic is_msg;
    logic is_cpl;
    logic has_data;
    logic req_any;
    logic type_bad;
    assign mem_req  = (in_pkt.typ[4:1] == 4'h0);
    assign is_io    = (in_pkt.typ == 5'h02) && !in_pkt.fmt[0];
    assign is_cfg   = (in_pkt.typ[4:1] == 4'h2) && !in_pkt.fmt[0];
    assign is_msg   = (in_pkt.typ[4:3] == 2'h2) && in_pkt.fmt[0];
    assign is_cpl   = (in_pkt.typ[4:1] == 4'h5) && !in_pkt.fmt[0];
    assign has_data = in_pkt.fmt[1];
    assign req_any  = mem_req || is_io || is_cfg;
    // Locked read has no write form
    assign type_bad = !(req_any || is_msg || is_cpl) ||
                      (mem_req && in_pkt.typ[0] && has_data);

    // Length and size checks
    logic [10:0] len_dw;
    logic [10:0] mps_dw;
    logic        size_bad;
    logic        len_mis;
    logic        td_mis;
    logic [11:0] end_dw;
    logic        cross_4k;
    assign len_dw   = (in_pkt.len == 10'h000) ? 11'h400 : {1'b0, in_pkt.len};
    // Reserved size codes behave as the largest size
    assign mps_dw   = 11'h020 << ((mps > 3'h5) ? 3'h5 : mps);
    assign size_bad = has_data && (len_dw > mps_dw);
    assign len_mis  = has_data && (in_pkt.payload_dw != len_dw);
    assign td_mis   = (in_pkt.td != in_pkt.ecrc_present);
    assign end_dw   = {2'h0, in_pkt.addr_dw} + {1'b0, len_dw};
    assign cross_4k = mem_req && (end_dw > 12'h400);

    // Messages that must use traffic class 0
    logic msg_tc0_kind;
    logic msg_bad;
    assign msg_tc0_kind = (in_pkt.msg_code == 8'h00) ||
                          (in_pkt.msg_code[7:3] == 5'h04) ||
                          (in_pkt.msg_code == 8'h14) || (in_pkt.msg_code == 8'h18) ||
                          (in_pkt.msg_code == 8'h19) || (in_pkt.msg_code == 8'h1b) ||
                          (in_pkt.msg_code == 8'h30) || (in_pkt.msg_code == 8'h31) ||
                          (in_pkt.msg_code == 8'h33);
    assign msg_bad = is_msg && msg_tc0_kind && (in_pkt.tc != 3'h0);

    // Byte enable checks
    logic fbe_cont;
    logic lbe_cont;
    logic be_bad;
    logic iocfg_bad;
    assign fbe_cont = (in_pkt.first_byte_enables == 4'hf) ||
                      (in_pkt.first_byte_enables == 4'he) ||
                      (in_pkt.first_byte_enables == 4'hc) ||
                      (in_pkt.first_byte_enables == 4'h8);
    assign lbe_cont = (in_pkt.last_byte_enables == 4'hf) ||
                      (in_pkt.last_byte_enables == 4'h7) ||
                      (in_pkt.last_byte_enables == 4'h3) ||
                      (in_pkt.last_byte_enables == 4'h1);
    assign be_bad = req_any && (
        ((in_pkt.first_byte_enables == 4'h0) && (len_dw > 11'h001)) ||
        ((in_pkt.last_byte_enables != 4'h0) && (len_dw == 11'h001)) ||
        ((in_pkt.last_byte_enables == 4'h0) && (len_dw > 11'h001)) ||
        (!(fbe_cont && lbe_cont) &&
         ((len_dw > 11'h002) ||
          ((len_dw == 11'h002) && in_pkt.addr_dw[0]))));
    // I/O and configuration requests share one restriction set
    assign iocfg_bad = (is_io || is_cfg) &&
                       ((in_pkt.tc != 3'h0) || (in_pkt.attr != 2'h0) ||
                        (len_dw != 11'h001) || (in_pkt.last_byte_enables != 4'h0));

    // Completion checks
    logic [12:0] bc_bytes;
    logic [12:0] cpl_bytes;
    logic [4:0]  cpl_end;
    logic        rcb_bad;
    logic        crs_bad;
    assign bc_bytes  = (in_pkt.byte_count == 12'h000) ? 13'h1000 : {1'b0, in_pkt.byte_count};
    assign cpl_bytes = {len_dw, 2'h0} - {11'h000, in_pkt.lower_addr[1:0]};
    assign cpl_end   = in_pkt.lower_addr[6:2] + len_dw[4:0];
    // A partial completion must end on the completion boundary
    assign rcb_bad = is_cpl && has_data && (bc_bytes > cpl_bytes) &&
                     (st_ff.ctrl[`PRC_C_RCB128] ? (cpl_end != 5'h00)
                                                : (cpl_end[3:0] != 4'h0));
    assign crs_bad = is_cpl && (in_pkt.cpl_status == 3'h2) &&
                     !in_pkt.req_was_cfg;

    // Error classification with malformed ahead of CRC ahead of poison
    logic mal_any;
    logic ecrc_err;
    logic poison;
    assign mal_any  = type_bad || size_bad || len_mis || td_mis || cross_4k ||
                      msg_bad || be_bad || iocfg_bad || rcb_bad || crs_bad;
    assign ecrc_err = in_pkt.ecrc_present && in_pkt.ecrc_bad && !mal_any;
    assign poison   = in_pkt.ep && !mal_any && !ecrc_err;

    // Next state: register access, error logging and forward tracking
    always_comb begin
        logic [`PRC_STAT_W-1:0] set;   // Status bits raised this cycle
        logic [`PRC_STAT_W-1:0] clr;   // Status bits cleared by software
        logic                   sev;   // Severity of the uncorrectable error
        logic                   send;  // Error message goes out
        set            = `PRC_STAT_RST;
        clr            = `PRC_STAT_RST;
        sev            = 1'b0;
        send           = 1'b0;
        nxt_st         = st_ff;
        nxt_st.pass         = 1'b0;
        nxt_st.drop         = 1'b0;
        nxt_st.msg_fatal    = 1'b0;
        nxt_st.msg_nonfatal = 1'b0;
        nxt_st.msg_cor      = 1'b0;
        nxt_st.rdata        = 32'h0000_0000;
        // Pin synchroniser
        nxt_st.perr_s1 = parity_error_pin_n;
        nxt_st.perr_s2 = st_ff.perr_s1;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `PRC_OFS_CTRL: begin
                    nxt_st.ctrl = reg_wdata[`PRC_CTRL_W-1:0];
                end
                `PRC_OFS_CLR: begin
                    clr = reg_wdata[`PRC_STAT_W-1:0];
                end
                `PRC_OFS_EN: begin
                    nxt_st.en = reg_wdata[`PRC_STAT_W-1:0];
                end
                default: begin
                    // Status is read only, unmapped writes ignored
                end
            endcase
        end

        // Register reads, unmapped and write-only addresses read zero
        if (reg_rd) begin
            case (reg_addr)
                `PRC_OFS_CTRL: nxt_st.rdata = {19'h0, st_ff.ctrl};
                `PRC_OFS_STAT: nxt_st.rdata = {20'h0, st_ff.stat};
                `PRC_OFS_EN:   nxt_st.rdata = {20'h0, st_ff.en};
                default:       nxt_st.rdata = 32'h0000_0000;
            endcase
        end

        // Every packet gets exactly one verdict before it moves on
        if (in_pkt.valid) begin
            if (mal_any) begin
                sev  = st_ff.ctrl[`PRC_C_MAL_SEV];
                send = sev ? (system_err_enable || fatal_en) : (system_err_enable || nfatal_en);
                set[`PRC_S_MAL]    = 1'b1;
                set[`PRC_S_FATAL]  = sev;
                set[`PRC_S_NFATAL] = !sev;
                set[`PRC_S_SSERR]  = send && system_err_enable;
                nxt_st.msg_fatal    = send && sev;
                nxt_st.msg_nonfatal = send && !sev;
                nxt_st.drop         = 1'b1;
            end else if (ecrc_err) begin
                sev  = st_ff.ctrl[`PRC_C_ECRC_SEV];
                send = sev ? (system_err_enable || fatal_en) : (system_err_enable || nfatal_en);
                set[`PRC_S_ECRC]   = 1'b1;
                set[`PRC_S_DPE]    = 1'b1;
                set[`PRC_S_FATAL]  = sev;
                set[`PRC_S_NFATAL] = !sev;
                set[`PRC_S_SSERR]  = send && system_err_enable;
                nxt_st.msg_fatal    = send && sev;
                nxt_st.msg_nonfatal = send && !sev;
                nxt_st.drop         = 1'b1;
            end else begin
                nxt_st.pass = 1'b1;
                if (poison) begin
                    sev = st_ff.ctrl[`PRC_C_POIS_SEV];
                    set[`PRC_S_POISON] = 1'b1;
                    set[`PRC_S_DPE]    = 1'b1;
                    if (sev) begin
                        // Fatal case
                        send = system_err_enable || fatal_en;
                        set[`PRC_S_FATAL] = 1'b1;
                        set[`PRC_S_SSERR] = send && system_err_enable;
                        nxt_st.msg_fatal  = send;
                    end else begin
                        // Advisory non-fatal case
                        set[`PRC_S_COR]  = 1'b1;
                        set[`PRC_S_ADVISORY_NONFATAL_FLAG] = 1'b1;
                        nxt_st.msg_cor   = cor_en;
                    end
                    // Poisoned read completion
                    set[`PRC_S_MDP_PRI] = is_cpl && has_data && perresp;
                    // Poisoned write headed for the parallel bus
                    if (mem_req && has_data) begin
                        nxt_st.fwd = FWD_WAIT;
                    end
                end
            end
        end

        // Secondary effects while a poisoned write is being forwarded
        case (st_ff.fwd)
            FWD_IDLE: begin
            end
            FWD_WAIT: begin
                set[`PRC_S_MDP_SEC] = speresp && !st_ff.perr_s2;
                if (sec_fwd_done) begin
                    set[`PRC_S_SEC_PERR] = 1'b1;
                    if (!(in_pkt.valid && poison && mem_req && has_data)) begin
                        nxt_st.fwd = FWD_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.fwd = FWD_IDLE;
            end
        endcase

        // Sticky status, a new event wins over a clear
        nxt_st.stat = (st_ff.stat & ~clr) | set;
        nxt_st.irq  = |(nxt_st.stat & st_ff.en);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.ctrl         <= `PRC_CTRL_RST;
            st_ff.stat         <= `PRC_STAT_RST;
            st_ff.en           <= `PRC_STAT_RST;
            st_ff.rdata        <= 32'h0000_0000;
            st_ff.perr_s1      <= 1'b1;
            st_ff.perr_s2      <= 1'b1;
            st_ff.fwd          <= FWD_IDLE;
            st_ff.pass         <= 1'b0;
            st_ff.drop         <= 1'b0;
            st_ff.msg_fatal    <= 1'b0;
            st_ff.msg_nonfatal <= 1'b0;
            st_ff.msg_cor      <= 1'b0;
            st_ff.irq          <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata    = st_ff.rdata;
    assign pkt_pass     = st_ff.pass;
    assign pkt_drop     = st_ff.drop;
    assign msg_fatal    = st_ff.msg_fatal;
    assign msg_nonfatal = st_ff.msg_nonfatal;
    assign msg_cor      = st_ff.msg_cor;
    assign irq          = st_ff.irq;

    // Checks on the verdicts
    a_ecrc_drop: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && ecrc_err |=> pkt_drop && !pkt_pass &&
            st_ff.stat[`PRC_S_ECRC] && st_ff.stat[`PRC_S_DPE])
        else $error("CRC error not logged and dropped");
    a_poison_log: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && poison |=> pkt_pass && st_ff.stat[`PRC_S_POISON] &&
            (st_ff.stat[`PRC_S_COR] || st_ff.stat[`PRC_S_FATAL]))
        else $error("Poisoned packet not logged");
    a_advisory_nonfatal_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && poison && !st_ff.ctrl[`PRC_C_POIS_SEV] |=>
            st_ff.stat[`PRC_S_ADVISORY_NONFATAL_FLAG] && (msg_cor == $past(cor_en)) && !msg_fatal)
        else $error("Advisory case not flagged");
    a_poison_serr: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && poison && !st_ff.stat[`PRC_S_SSERR] |=>
            st_ff.stat[`PRC_S_SSERR] == (msg_fatal && $past(system_err_enable)))
        else $error("System error flag wrong for poisoned packet");
    a_mdp_pri: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && poison && is_cpl && has_data && perresp |=>
            st_ff.stat[`PRC_S_MDP_PRI])
        else $error("Master data parity not set");
    a_sec_perr: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff.fwd == FWD_WAIT && sec_fwd_done |=> st_ff.stat[`PRC_S_SEC_PERR])
        else $error("Secondary parity status not set");
    a_mal_drop: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && mal_any |=> pkt_drop && st_ff.stat[`PRC_S_MAL] &&
            (st_ff.stat[`PRC_S_FATAL] || st_ff.stat[`PRC_S_NFATAL]))
        else $error("Malformed packet not discarded");
    a_one_verdict: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid |=> (pkt_pass ^ pkt_drop) ##1 !(pkt_pass && pkt_drop))
        else $error("Packet verdict not unique");
    a_td_mis: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && (in_pkt.td != in_pkt.ecrc_present) |=> pkt_drop)
        else $error("Digest mismatch not discarded");
    a_clr_set: assert property (@(posedge clk) disable iff (!rst_n)
        in_pkt.valid && mal_any && reg_wr && reg_addr == `PRC_OFS_CLR |=>
            st_ff.stat[`PRC_S_MAL])
        else $error("Clear won over new event");

endmodule : prc_rx_checker

/* verification/prc_link_partner.sv */
// Upstream port and parallel-bus target model facing the checker
`timescale 1ns/1ps
module prc_link_partner
    import prc_pkg::*;
(
    input  wire logic clk,               // Core clock
    input  wire logic rst_n,             // Asynchronous reset, active low
    input  wire logic send,              // Launch one packet
    input  prc_pkt_s  pkt,               // Packet to launch
    input  wire logic fwd_go,            // Start a write forward with bad parity
    output prc_pkt_s  in_pkt,            // Packet towards the checker
    output logic      sec_fwd_done,      // Forward has ended on the parallel bus
    output logic      parity_error_pin_n // Target parity pin, active low
);
    logic [2:0] cnt_ff; // Cycles left of the bad-parity forward

    // Packet stands one cycle; an idle bus inverts the previous fields every cycle, with valid low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_pkt <= '0;
        end else begin
            in_pkt <= send ? pkt : {1'b0, ~in_pkt[$bits(prc_pkt_s)-2:0]};
        end
    end

    // Target holds its parity pin low for the whole forward
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= fwd_go ? 3'h4 : ((cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0);
        end
    end
    assign parity_error_pin_n = (cnt_ff == 3'h0);
    assign sec_fwd_done       = (cnt_ff == 3'h1);
endmodule : prc_link_partner

/* verification/tb.sv */
// Self-checking bench for the receive packet error checker
`timescale 1ns/1ps
`include "prc_regs.svh"
module tb;
    import prc_pkg::*;
    logic        clk, rst_n, send, fwd_go, sec_fwd_done, perr_n; // Stimulus and partner wires
    logic        reg_wr, reg_rd, pkt_pass, pkt_drop, msg_fatal, msg_nonfatal, msg_cor, irq;
    logic [7:0]  reg_addr;   // Register address
    logic [31:0] reg_wdata;  // Register write data
    logic [31:0] reg_rdata;  // Register read data
    logic [31:0] d;          // Last value read back
    prc_pkt_s    pkt, in_pkt; // Packet to send, packet on the link
    int          n_fail, checked, cycles;

    prc_rx_checker u_prc_rx_checker (.clk(clk), .rst_n(rst_n), .in_pkt(in_pkt),
        .sec_fwd_done(sec_fwd_done), .parity_error_pin_n(perr_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pkt_pass(pkt_pass), .pkt_drop(pkt_drop), .msg_fatal(msg_fatal),
        .msg_nonfatal(msg_nonfatal), .msg_cor(msg_cor), .irq(irq));
    prc_link_partner u_prc_link_partner (.clk(clk), .rst_n(rst_n), .send(send), .pkt(pkt),
        .fwd_go(fwd_go), .in_pkt(in_pkt), .sec_fwd_done(sec_fwd_done),
        .parity_error_pin_n(perr_n));

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Send a packet and check the verdict and message pulses
    task automatic tx(input prc_pkt_s p, input logic drop, input logic [2:0] msg);
        @(posedge clk);
        pkt  <= p;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        #1;
        chk({pkt_drop, pkt_pass}, {drop, ~drop});
        chk({msg_fatal, msg_nonfatal, msg_cor}, msg);
    endtask : tx

    // Check status and interrupt, then clear all status
    task automatic st_chk(input logic [11:0] exp);
        rd(`PRC_OFS_STAT);
        chk(d, exp);
        chk(irq, exp != 12'h0);
        wr(`PRC_OFS_CLR, 32'hfff);
        #1 chk(irq, 1'b0);
    endtask : st_chk

    // Clean two-word memory write
    function automatic prc_pkt_s base();
        prc_pkt_s p;
        p = '0;
        {p.valid, p.fmt, p.len, p.payload_dw} = {1'b1, 2'b10, 10'd2, 11'd2};
        {p.first_byte_enables, p.last_byte_enables, p.byte_count} = {8'hff, 12'd8};
        return p;
    endfunction : base

    // One malformed packet for each index
    function automatic prc_pkt_s bad(input int k);
        prc_pkt_s p;
        p = base();
        case (k)
            0: p.len = 10'd33;
            1: p.payload_dw = 11'd3;
            2: p.td = 1'b1;
            3: p.addr_dw = 10'h3ff;
            4: {p.fmt, p.typ, p.tc, p.msg_code} = {2'b01, 5'b10100, 3'h1, 8'h20};
            5: {p.fmt, p.typ, p.tc, p.msg_code} = {2'b01, 5'b10000, 3'h2, 8'h18};
            6: {p.fmt, p.typ, p.tc, p.msg_code} = {2'b01, 5'b10000, 3'h1, 8'h30};
            7: {p.fmt, p.typ, p.tc, p.msg_code} = {2'b01, 5'b10011, 3'h7, 8'h00};
            8: {p.fmt, p.typ} = {2'b00, 5'b00111};
            9: p.first_byte_enables = 4'h0;
            10: p.len = 10'd1;
            11: p.last_byte_enables = 4'h0;
            12: {p.len, p.first_byte_enables} = {10'd3, 4'h5};
            13: {p.addr_dw, p.first_byte_enables} = {10'h1, 4'h5};
            22: {p.fmt, p.typ, p.cpl_status} = {2'b00, 5'b01010, 3'b010};
            23: {p.typ, p.byte_count} = {5'b01010, 12'd256};
            default: begin
                // Single-word I/O (14-17) or configuration (18-21) write, one field spoiled
                {p.typ, p.len, p.last_byte_enables} = {(k < 18) ? 5'b00010 : 5'b00100, 10'd1, 4'h0};
                case (k % 4)
                    2: p.tc = 3'h1;
                    3: p.attr = 2'h1;
                    0: p.len = 10'd2;
                    default: p.last_byte_enables = 4'h1;
                endcase
            end
        endcase
        // Keep carried payload equal to the length unless the mismatch is the point
        if (k != 1) p.payload_dw = p.fmt[1] ? {1'b0, p.len} : 11'h0;
        return p;
    endfunction : bad

    // Final counts and verdict
    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        {rst_n, send, fwd_go, reg_wr, reg_rd, reg_addr, reg_wdata, pkt} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PRC_OFS_CTRL);
        chk(d, 32'h80);
        rd(8'h10);
        chk(d, 32'h0);
        rd(`PRC_OFS_CLR);
        chk(d, 32'h0);
        wr(`PRC_OFS_STAT, 32'hfff);
        st_chk(12'h000);
        wr(`PRC_OFS_EN, 32'hfff);
        wr(`PRC_OFS_CTRL, 32'h0ff);
        tx(base(), 1'b0, 3'b000);
        st_chk(12'h000);
        pkt = base();
        {pkt.td, pkt.ecrc_present, pkt.ecrc_bad} = 3'b111;
        tx(pkt, 1'b1, 3'b100);
        st_chk(12'h071);
        pkt = base();
        {pkt.typ, pkt.ep} = {5'b01010, 1'b1};
        tx(pkt, 1'b0, 3'b001);
        st_chk(12'h31a);
        for (int k = 0; k < 24; k++) begin
            tx(bad(k), 1'b1, 3'b100);
            st_chk(12'h064);
        end
        wr(`PRC_OFS_CTRL, 32'h1ff);
        pkt = base();
        pkt.ep = 1'b1;
        tx(pkt, 1'b0, 3'b100);
        @(posedge clk);
        fwd_go <= 1'b1;
        @(posedge clk);
        fwd_go <= 1'b0;
        repeat (8) @(posedge clk);
        st_chk(12'hc72);
        wr(`PRC_OFS_EN, 32'h0);
        tx(bad(3), 1'b1, 3'b100);
        chk(irq, 1'b0);
        wr(`PRC_OFS_EN, 32'hfff);
        @(posedge clk);
        #1 chk(irq, 1'b1);
        st_chk(12'h064);
        // Non-fatal malformed case, with a clear landing on the same edge as the event
        wr(`PRC_OFS_CTRL, 32'h07f);
        fork
            tx(bad(3), 1'b1, 3'b010);
            begin
                @(posedge clk);
                wr(`PRC_OFS_CLR, 32'hfff);
            end
        join
        st_chk(12'h0a4);
        report_and_stop();
    end
endmodule : tb
